// file: hdl/adc_cfg_cfg.svh
// Constants for the ADC configuration front end and its host.
// Assumes inclusion by bare name; definitions only.
`ifndef ADC_CFG_CFG_SVH
`define ADC_CFG_CFG_SVH

`define WORD_BITS          16
`define ADDR_BITS          5
`define DATA_BITS          11
`define REG_COUNT          32
`define REG_RESET_VAL      11'h000
`define REG_RESET_POWER    5'h00
`define REG_TEST_PATTERN   5'h0A
`define REG_OVERRIDE       5'h0D
`define BIT_SOFT_RESET     10
`define BIT_REF_INTERNAL   5
`define BIT_PDN_CH_HI      4
`define BIT_PDN_CH_LO      1
`define BIT_PDN_GLOBAL     0
`define BIT_DATA_FORMAT    9
`define BIT_PATTERN_HI     7
`define BIT_PATTERN_LO     5
`define BIT_OVERRIDE       10
`define BIT_BYTE_WISE      7
`define BIT_LSB_FIRST      6
`define BIT_COARSE_GAIN    5
`define BIT_CAPTURE_RISE   4
`define BIT_SERIALIZE_16   2
`define BIT_SDR_CLOCK      1
`define BIT_TWO_WIRE       0
`define PAT_NORMAL         3'h0
`define PAT_SYNC           3'h1
`define PAT_DESKEW         3'h2
`define STRAP_SETTLE       2'h3

`define PCLK_PERIOD_NS     25
`define RESET_PULSE_NS     10
`define RESET_PULSE_CYC    ((`RESET_PULSE_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define SCLK_HALF_NS       100
`define SCLK_HALF_CYC      (`SCLK_HALF_NS / `PCLK_PERIOD_NS)

`define HOST_CMD           12'h000
`define HOST_CTRL          12'h004
`define HOST_STATUS        12'h008
`define CMD_KEEP_ENABLE    16
`define CTRL_RESET_LEVEL   0
`define CTRL_PARK_ENABLE   1
`define CTRL_PARK_SCLK     2
`define CTRL_PARK_DATA     3
`define CTRL_RESET_PULSE   4
`define CTRL_RESET_VAL     4'h2

`endif

// file: hdl/adc_cfg_pkg.sv
// Types shared by both ends of the ADC configuration link.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_cfg_pkg;
   typedef logic [1:0]  strap_type;
   typedef logic [10:0] reg_data_type;
   typedef enum {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TAIL, H_HOLD} host_state_type;
   typedef struct packed {
      logic       serial_mode;
      logic       two_wire;
      logic       sdr_clock;
      logic       serialize_16;
      logic       capture_rising;
      logic       lsb_first;
      logic       offset_binary;
      logic       byte_wise;
      logic       coarse_gain_on;
      logic       ref_internal;
      logic       global_powerdown;
      logic [3:0] channel_powerdown;
      logic [2:0] test_pattern;
   } mode_type;
endpackage

// file: hdl/adc_link_if.sv
// Pins between the host controller and the ADC configuration port.
// Assumes the bench joins both ends through one instance.
interface adc_link_if;
   logic serial_enable;    // Low while serial shifting is active
   logic serial_clock_pin; // Sampled by the device on falling edges
   logic serial_data_pin;  // Address then data, first bit first
   logic reset_pin;        // High pulse resets, held high selects pins

   modport device (input serial_enable, input serial_clock_pin,
                   input serial_data_pin, input reset_pin);
   modport host (output serial_enable, output serial_clock_pin,
                 output serial_data_pin, output reset_pin);
endinterface

// file: hdl/adc_cfg_device.sv
// Configuration front end of the ADC: strap decode and serial port.
// Assumes link pins and strap codes are asynchronous to pclk.
`include "adc_cfg_cfg.svh"

module adc_cfg_device
   import adc_cfg_pkg::*;
(
   input  wire logic pclk,           // Device clock, 40 MHz
   input  wire logic presetn,        // Power-on reset, active low
   adc_link_if.device link,          // Serial and reset pins
   input  wire strap_type enable_level, // Comparator code of the enable pin
   input  wire strap_type cfg_one,   // Code of config_pin_one
   input  wire strap_type cfg_two,   // Code of config_pin_two
   input  wire strap_type cfg_four,  // Code of config_pin_four
   input  wire logic power_down_pin, // Global power down pin
   output mode_type      mode        // Resolved configuration
);

   logic [4:0]   pin_s1_q;
   logic [4:0]   pin_s2_q;
   logic [7:0]   strap_s1_q;
   logic [7:0]   strap_s2_q;
   logic [7:0]   strap_q;
   logic [7:0]   strap_d;
   logic [1:0]   settle_q;
   logic [1:0]   settle_d;
   logic         enable_s;
   logic         sclk_s;
   logic         data_s;
   logic         rpin_s;
   logic         pdn_s;
   logic         sclk_prev_q;
   logic         fall;
   logic [15:0]  shift_q;
   logic [15:0]  shift_d;
   logic [3:0]   count_q;
   logic [3:0]   count_d;
   logic         wr_en;
   logic [15:0]  word;
   logic [4:0]   wr_addr;
   reg_data_type wr_data;
   logic         catch_q;
   logic         catch_d;
   logic         catch_s1_q;
   logic         pin_reset_q;
   reg_data_type regs_q [`REG_COUNT];
   reg_data_type regs_d [`REG_COUNT];
   reg_data_type r_pwr;
   reg_data_type r_pat;
   reg_data_type r_ovr;
   logic         ovrd;
   mode_type     mode_d;

   // Two-stage synchronisers for pins and strap codes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q   <= 5'h00;
         pin_s2_q   <= 5'h00;
         strap_s1_q <= 8'h00;
         strap_s2_q <= 8'h00;
      end else begin
         pin_s1_q   <= {power_down_pin, link.reset_pin, link.serial_data_pin,
                        link.serial_clock_pin, link.serial_enable};
         pin_s2_q   <= pin_s1_q;
         strap_s1_q <= {enable_level, cfg_one, cfg_two, cfg_four};
         strap_s2_q <= strap_s1_q;
      end
   end

   assign enable_s = pin_s2_q[0];
   assign sclk_s   = pin_s2_q[1];
   assign data_s   = pin_s2_q[2];
   assign rpin_s   = pin_s2_q[3];
   assign pdn_s    = pin_s2_q[4];

   always_comb begin
      strap_d  = strap_q;
      settle_d = settle_q;
      if (settle_q != `STRAP_SETTLE) begin
         strap_d  = strap_s2_q;
         settle_d = settle_q + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_q  <= 8'h00;
         settle_q <= 2'h0;
      end else begin
         strap_q  <= strap_d;
         settle_q <= settle_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn or posedge link.reset_pin) begin
      if (!presetn) begin
         catch_q <= 1'b0;
      end else if (link.reset_pin) begin
         catch_q <= 1'b1;
      end else begin
         catch_q <= catch_d;
      end
   end

   assign catch_d = pin_reset_q ? 1'b0 : catch_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         catch_s1_q  <= 1'b0;
         pin_reset_q <= 1'b0;
      end else begin
         catch_s1_q  <= catch_q;
         pin_reset_q <= catch_s1_q;
      end
   end

   // Edge found by sampling, duty cycle free
   assign fall    = sclk_prev_q & ~sclk_s;
   assign word    = {shift_q[14:0], data_s};
   assign wr_addr = word[15:11];
   assign wr_data = word[10:0];

   always_comb begin
      shift_d = shift_q;
      count_d = count_q;
      wr_en   = 1'b0;
      // Serial port idle in pin mode or enable high
      if (enable_s | rpin_s) begin
         count_d = 4'h0;
      // Shift on falling edge while enabled
      end else if (fall) begin
         shift_d = word;
         count_d = count_q + 4'h1;
         // Load only on each sixteenth edge
         if (count_q == 4'hF) begin
            wr_en = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_prev_q <= 1'b0;
         shift_q     <= 16'h0000;
         count_q     <= 4'h0;
      end else begin
         sclk_prev_q <= sclk_s;
         shift_q     <= shift_d;
         count_q     <= count_d;
      end
   end

   // Register file: written only, never read back
   always_comb begin
      regs_d = regs_q;
      // Pin pulse or soft reset restores defaults
      if (pin_reset_q | (wr_en && wr_addr == `REG_RESET_POWER &&
                         wr_data[`BIT_SOFT_RESET])) begin
         for (int i = 0; i < `REG_COUNT; i++) begin
            regs_d[i] = `REG_RESET_VAL;
         end
      // Stored the cycle after the edge is seen
      end else if (wr_en) begin
         regs_d[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `REG_COUNT; i++) begin
            regs_q[i] <= `REG_RESET_VAL;
         end
      end else begin
         regs_q <= regs_d;
      end
   end

   assign r_pwr = regs_q[`REG_RESET_POWER];
   assign r_pat = regs_q[`REG_TEST_PATTERN];
   assign r_ovr = regs_q[`REG_OVERRIDE];
   assign ovrd  = r_ovr[`BIT_OVERRIDE];

   always_comb begin
      mode_d = '0;
      mode_d.serial_mode = ~rpin_s;
      case (strap_q[5:4])
         2'h2:    {mode_d.two_wire, mode_d.sdr_clock} = 2'b11;
         2'h3:    {mode_d.two_wire, mode_d.sdr_clock} = 2'b10;
         default: {mode_d.two_wire, mode_d.sdr_clock} = 2'b00;
      endcase
      case (strap_q[3:2])
         2'h0:    {mode_d.serialize_16, mode_d.capture_rising} = 2'b00;
         2'h1:    {mode_d.serialize_16, mode_d.capture_rising} = 2'b10;
         2'h2:    {mode_d.serialize_16, mode_d.capture_rising} = 2'b11;
         default: {mode_d.serialize_16, mode_d.capture_rising} = 2'b01;
      endcase
      case (strap_q[1:0])
         2'h0:    {mode_d.lsb_first, mode_d.offset_binary} = 2'b00;
         2'h1:    {mode_d.lsb_first, mode_d.offset_binary} = 2'b01;
         2'h2:    {mode_d.lsb_first, mode_d.offset_binary} = 2'b11;
         default: {mode_d.lsb_first, mode_d.offset_binary} = 2'b10;
      endcase
      if (!rpin_s) begin
         // Override hands strap modes to registers
         if (ovrd) begin
            mode_d.two_wire       = r_ovr[`BIT_TWO_WIRE];
            mode_d.sdr_clock      = r_ovr[`BIT_SDR_CLOCK];
            mode_d.serialize_16   = r_ovr[`BIT_SERIALIZE_16];
            mode_d.capture_rising = r_ovr[`BIT_CAPTURE_RISE];
            mode_d.lsb_first      = r_ovr[`BIT_LSB_FIRST];
            mode_d.byte_wise      = r_ovr[`BIT_BYTE_WISE];
            mode_d.offset_binary  = r_pat[`BIT_DATA_FORMAT];
         end
         // Gain gated by override, rest from registers
         mode_d.coarse_gain_on    = ovrd & r_ovr[`BIT_COARSE_GAIN];
         mode_d.ref_internal      = r_pwr[`BIT_REF_INTERNAL];
         mode_d.test_pattern      = r_pat[`BIT_PATTERN_HI:`BIT_PATTERN_LO];
         mode_d.channel_powerdown = r_pwr[`BIT_PDN_CH_HI:`BIT_PDN_CH_LO];
         mode_d.global_powerdown  = pdn_s | r_pwr[`BIT_PDN_GLOBAL];
      end else begin
         case (strap_q[7:6])
            2'h0:    {mode_d.ref_internal, mode_d.coarse_gain_on} = 2'b00;
            2'h1:    {mode_d.ref_internal, mode_d.coarse_gain_on} = 2'b01;
            2'h2:    {mode_d.ref_internal, mode_d.coarse_gain_on} = 2'b11;
            default: {mode_d.ref_internal, mode_d.coarse_gain_on} = 2'b10;
         endcase
         // Clock and data pins as two static bits
         case ({sclk_s, data_s})
            2'b01:   mode_d.test_pattern = `PAT_SYNC;
            2'b11:   mode_d.test_pattern = `PAT_DESKEW;
            default: mode_d.test_pattern = `PAT_NORMAL;
         endcase
         // Pin forces power down in pin mode too
         mode_d.global_powerdown = pdn_s | (sclk_s & ~data_s);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= '0;
      end else begin
         mode <= mode_d;
      end
   end

endmodule

// file: hdl/adc_cfg_host.sv
// Host controller that drives the ADC serial and reset pins.
// Assumes an APB master on pclk; pins go straight to the link.
`include "adc_cfg_cfg.svh"

module adc_cfg_host
   import adc_cfg_pkg::*;
#(
   parameter logic [7:0] HALF_CYC = 8'(`SCLK_HALF_CYC) // Serial clock half period
)(
   input  wire logic        pclk,    // Host clock, 40 MHz
   input  wire logic        presetn, // Asynchronous reset, active low
   input  wire logic        psel,    // APB select
   input  wire logic        penable, // APB access phase
   input  wire logic        pwrite,  // APB direction, high writes
   input  wire logic [11:0] paddr,   // APB byte address
   input  wire logic [31:0] pwdata,  // APB write data
   output logic      [31:0] prdata,  // APB read data
   output logic             pready,  // APB ready, always high
   output logic             pslverr, // APB error on unmapped address
   adc_link_if.host         link     // Serial and reset pins
);

   host_state_type state_q;
   host_state_type state_d;
   logic [7:0]     div_q;
   logic [7:0]     div_d;
   logic [3:0]     bit_q;
   logic [3:0]     bit_d;
   logic [15:0]    shift_q;
   logic [15:0]    shift_d;
   logic           keep_q;
   logic           keep_d;
   logic [3:0]     ctrl_q;
   logic [3:0]     ctrl_d;
   logic [1:0]     pulse_q;
   logic [1:0]     pulse_d;
   logic           en_q;
   logic           en_d;
   logic           sclk_q;
   logic           sclk_d;
   logic           dat_q;
   logic           dat_d;
   logic           rpin_q;
   logic           rpin_d;
   logic [31:0]    prdata_d;
   logic           wr;
   logic           ready_for_cmd;
   logic           half_done;

   assign pready        = 1'b1;
   assign wr            = psel & penable & pwrite;
   assign pslverr       = psel & penable & ~(paddr == `HOST_CMD ||
                          paddr == `HOST_CTRL || paddr == `HOST_STATUS);
   assign ready_for_cmd = (state_q == H_IDLE || state_q == H_HOLD) &&
                          pulse_q == 2'h0;
   assign half_done     = div_q == HALF_CYC - 8'h01;

   always_comb begin
      state_d  = state_q;
      div_d    = half_done ? 8'h00 : div_q + 8'h01;
      bit_d    = bit_q;
      shift_d  = shift_q;
      keep_d   = keep_q;
      ctrl_d   = ctrl_q;
      pulse_d  = (pulse_q != 2'h0) ? pulse_q - 2'h1 : 2'h0;
      prdata_d = prdata;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `HOST_CTRL:   prdata_d = {28'h0000000, ctrl_q};
            `HOST_STATUS: prdata_d = {30'h0, pulse_q != 2'h0,
                                      !ready_for_cmd};
            default:      prdata_d = 32'h00000000;
         endcase
      end
      if (wr && paddr == `HOST_CTRL) begin
         ctrl_d = pwdata[3:0];
         // Reset pulse wider than 10 ns
         if (pwdata[`CTRL_RESET_PULSE]) begin
            pulse_d = 2'(`RESET_PULSE_CYC);
         end
      end
      case (state_q)
         H_IDLE, H_HOLD: begin
            // Word accepted only with reset pin low
            if (wr && paddr == `HOST_CMD && ready_for_cmd &&
                !ctrl_q[`CTRL_RESET_LEVEL]) begin
               shift_d = pwdata[15:0];
               keep_d  = pwdata[`CMD_KEEP_ENABLE];
               bit_d   = 4'h0;
               div_d   = 8'h00;
               state_d = (state_q == H_HOLD) ? H_HIGH : H_LEAD;
            end
         end
         H_LEAD: if (half_done) state_d = H_HIGH;
         H_HIGH: if (half_done) state_d = H_LOW;
         H_LOW: begin
            if (half_done) begin
               shift_d = {shift_q[14:0], 1'b0};
               bit_d   = bit_q + 4'h1;
               if (bit_q != 4'hF) begin
                  state_d = H_HIGH;
               // Keep enable low for a following word
               end else begin
                  state_d = keep_q ? H_HOLD : H_TAIL;
               end
            end
         end
         H_TAIL: if (half_done) state_d = H_IDLE;
         default: state_d = H_IDLE;
      endcase
   end

   always_comb begin
      en_d    = ctrl_q[`CTRL_PARK_ENABLE];
      sclk_d  = ctrl_q[`CTRL_PARK_SCLK];
      dat_d   = ctrl_q[`CTRL_PARK_DATA];
      rpin_d  = ctrl_q[`CTRL_RESET_LEVEL] | (pulse_q != 2'h0);
      if (state_q != H_IDLE) begin
         en_d    = 1'b0;
         sclk_d  = state_q == H_HIGH;
         dat_d   = shift_q[15];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= H_IDLE;
         div_q   <= 8'h00;
         bit_q   <= 4'h0;
         shift_q <= 16'h0000;
         keep_q  <= 1'b0;
         ctrl_q  <= `CTRL_RESET_VAL;
         pulse_q <= 2'h0;
         en_q    <= 1'b1;
         sclk_q  <= 1'b0;
         dat_q   <= 1'b0;
         rpin_q  <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         state_q <= state_d;
         div_q   <= div_d;
         bit_q   <= bit_d;
         shift_q <= shift_d;
         keep_q  <= keep_d;
         ctrl_q  <= ctrl_d;
         pulse_q <= pulse_d;
         en_q    <= en_d;
         sclk_q  <= sclk_d;
         dat_q   <= dat_d;
         rpin_q  <= rpin_d;
         prdata  <= prdata_d;
      end
   end

   assign link.serial_enable    = en_q;
   assign link.serial_clock_pin = sclk_q;
   assign link.serial_data_pin  = dat_q;
   assign link.reset_pin        = rpin_q;

endmodule

// file: test/adc_cfg_link_sva.sv
// Checker for the configuration link between host and device.
// Assumes instantiation beside the link interface in the bench.
`include "adc_cfg_cfg.svh"

module adc_cfg_link_sva
   import adc_cfg_pkg::*;
(
   input wire logic     pclk,             // Common clock
   input wire logic     presetn,          // Reset, active low
   input wire logic     serial_enable,    // Link enable
   input wire logic     serial_clock_pin, // Link clock
   input wire logic     serial_data_pin,  // Link data
   input wire logic     reset_pin,        // Link reset
   input wire logic     power_down_pin,   // Device power down pin
   input wire mode_type mode              // Device mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence shift_fall;
      !serial_enable && !reset_pin && $fell(serial_clock_pin);
   endsequence

   sequence short_pulse;
      $rose(reset_pin) ##1 !reset_pin;
   endsequence

   sel_mode_a: assert property (
      $stable(reset_pin) [*8] |-> mode.serial_mode == !reset_pin)
      else $error("serial mode does not follow reset pin");
   pin_pattern_a: assert property (
      (reset_pin && $stable({serial_clock_pin, serial_data_pin})) [*8] |->
      mode.test_pattern == (serial_data_pin ? (serial_clock_pin ? `PAT_DESKEW : `PAT_SYNC)
                                            : `PAT_NORMAL))
      else $error("pin pattern wrong");
   pdn_force_a: assert property (
      power_down_pin [*6] |-> mode.global_powerdown)
      else $error("power down pin ignored");
   data_hold_a: assert property (
      shift_fall |-> $stable(serial_data_pin) ##1 $stable(serial_data_pin))
      else $error("data moves at sampling edge");
   enable_lead_a: assert property (
      $fell(serial_enable) && !reset_pin |-> !serial_clock_pin)
      else $error("enable falls with clock high");
   enable_tail_a: assert property (
      $rose(serial_enable) && !reset_pin |-> !serial_clock_pin)
      else $error("enable rises with clock high");
   clk_phase_a: assert property (
      $rose(serial_clock_pin) && !serial_enable && !reset_pin |=> serial_clock_pin)
      else $error("serial clock high phase too short");
   pulse_clear_a: assert property (
      short_pulse |-> ##[1:6] mode.channel_powerdown == 4'h0)
      else $error("reset pulse left registers set");
endmodule

// file: test/tb_adc_config_serial_and_pin_control.sv
// Bench joining host and device through the link interface.
// Assumes APB stimulus on pclk; straps set at resets and changed later only to check they are held.
`include "adc_cfg_cfg.svh"

module tb_adc_config_serial_and_pin_control import adc_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   strap_type   enable_level = 2'h0;
   strap_type   cfg_one = 2'h0;
   strap_type   cfg_two = 2'h0;
   strap_type   cfg_four = 2'h0;
   logic        power_down_pin = 1'b0;
   mode_type    mode;
   logic [31:0] rdat;
   logic        rerr;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cycle_count = 0;
   wire logic [6:0] strap_view = {mode.two_wire, mode.sdr_clock, mode.serialize_16,
      mode.lsb_first, mode.offset_binary, mode.coarse_gain_on, mode.ref_internal};
   wire logic [5:0] ovr_view = {mode.two_wire, mode.sdr_clock, mode.serialize_16,
      mode.capture_rising, mode.lsb_first, mode.coarse_gain_on};

   adc_link_if u_adc_link_if ();

   adc_cfg_host u_adc_cfg_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_adc_link_if));

   adc_cfg_device u_adc_cfg_device (.pclk(pclk), .presetn(presetn), .link(u_adc_link_if),
      .enable_level(enable_level), .cfg_one(cfg_one), .cfg_two(cfg_two), .cfg_four(cfg_four),
      .power_down_pin(power_down_pin), .mode(mode));

   adc_cfg_link_sva u_chk (.pclk(pclk), .presetn(presetn),
      .serial_enable(u_adc_link_if.serial_enable),
      .serial_clock_pin(u_adc_link_if.serial_clock_pin),
      .serial_data_pin(u_adc_link_if.serial_data_pin),
      .reset_pin(u_adc_link_if.reset_pin), .power_down_pin(power_down_pin), .mode(mode));

   always #12.5 pclk = ~pclk;

   always @(posedge pclk) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset(input strap_type s);
      @(posedge pclk);
      presetn <= 1'b0;
      enable_level <= s;
      cfg_one <= s;
      cfg_two <= s;
      cfg_four <= s;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask

   task automatic send(input logic [15:0] w, input logic keep);
      apb(1'b1, `HOST_CMD, {15'h0, keep, w});
      do apb(1'b0, `HOST_STATUS, 32'h0); while (rdat[0] !== 1'b0);
      if (!keep) repeat (8) @(posedge pclk);
   endtask

   // Drives the link pins by hand through the park levels
   task automatic bang(input logic [15:0] w, input int n, input logic en);
      apb(1'b1, `HOST_CTRL, {28'h0, 2'b00, en, 1'b0});
      for (int k = 15; k > 15 - n; k--) begin
         apb(1'b1, `HOST_CTRL, {28'h0, w[k], 1'b1, en, 1'b0});
         apb(1'b1, `HOST_CTRL, {28'h0, w[k], 1'b0, en, 1'b0});
      end
      apb(1'b1, `HOST_CTRL, 32'h2);
      repeat (8) @(posedge pclk);
   endtask

   task automatic t_regs();
      apb(1'b0, `HOST_CTRL, 32'h0);
      chk("ctrl reset", {28'h0, `CTRL_RESET_VAL}, rdat);
      apb(1'b0, `HOST_STATUS, 32'h0);
      chk("status idle", 32'h0, rdat);
      chk("mapped err", 32'h0, {31'h0, rerr});
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      chk("unmapped data", 32'h0, rdat);
   endtask

   task automatic t_straps();
      logic [6:0] tbl [4];
      logic [2:0] pat [4];
      tbl = '{7'h00, 7'h16, 7'h7F, 7'h49};
      pat = '{`PAT_NORMAL, `PAT_NORMAL, `PAT_SYNC, `PAT_DESKEW};
      for (int i = 0; i < 4; i++) begin
         do_reset(2'(i));
         apb(1'b1, `HOST_CTRL, 32'h3);
         repeat (10) @(posedge pclk);
         chk("strap decode", {25'h0, tbl[i]}, {25'h0, strap_view});
         if (i == 2) chk("capture edge", 32'h1, {31'h0, mode.capture_rising});
         cfg_one <= 2'(i + 1);
         cfg_two <= 2'(i + 1);
         cfg_four <= 2'(i + 1);
         repeat (10) @(posedge pclk);
         chk("strap held", {25'h0, tbl[i]}, {25'h0, strap_view});
      end
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, `HOST_CTRL, {28'h0, 2'(p), 2'h3});
         repeat (12) @(posedge pclk);
         chk("pin pattern", {29'h0, pat[p]}, {29'h0, mode.test_pattern});
         chk("pin powerdown", {31'h0, p == 1}, {31'h0, mode.global_powerdown});
      end
   endtask

   task automatic t_serial();
      chk("serial mode", 32'h1, {31'h0, mode.serial_mode});
      send({5'h0D, 11'h4F7}, 1'b0);
      chk("override on", 32'h3F, {26'h0, ovr_view});
      chk("byte wise", 32'h1, {31'h0, mode.byte_wise});
      send({5'h0A, 11'h200}, 1'b0);
      chk("data format", 32'h1, {31'h0, mode.offset_binary});
      send({5'h0D, 11'h0F7}, 1'b0);
      chk("override off", 32'h0, {26'h0, ovr_view});
      send({5'h00, 11'h034}, 1'b1);
      send({5'h0A, 11'h040}, 1'b0);
      chk("word one", 32'hA, {28'h0, mode.channel_powerdown});
      chk("reference", 32'h1, {31'h0, mode.ref_internal});
      chk("word two", {29'h0, `PAT_DESKEW}, {29'h0, mode.test_pattern});
      bang({5'h00, 11'h01E}, 16, 1'b1);
      chk("enable high", 32'hA, {28'h0, mode.channel_powerdown});
      bang({5'h00, 11'h008}, 16, 1'b0);
      chk("slow word", 32'h4, {28'h0, mode.channel_powerdown});
      bang(16'hFFFF, 12, 1'b0);
      send({5'h00, 11'h006}, 1'b0);
      chk("partial drop", 32'h3, {28'h0, mode.channel_powerdown});
      send({5'h0D, 11'h4F7}, 1'b0);
      send({5'h00, 11'h400}, 1'b0);
      chk("soft reset", 32'h0, {26'h0, ovr_view});
      chk("soft reset pd", 32'h0, {28'h0, mode.channel_powerdown});
      send({5'h00, 11'h00C}, 1'b0);
      chk("self clear", 32'h6, {28'h0, mode.channel_powerdown});
      apb(1'b1, `HOST_CTRL, 32'h12);
      repeat (10) @(posedge pclk);
      chk("pulse reset", 32'h0, {28'h0, mode.channel_powerdown});
   endtask

   task automatic t_pdn();
      power_down_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("pdn pin", 32'h1, {31'h0, mode.global_powerdown});
      power_down_pin <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("pdn released", 32'h0, {31'h0, mode.global_powerdown});
      send({5'h00, 11'h001}, 1'b0);
      chk("pdn register", 32'h1, {31'h0, mode.global_powerdown});
   endtask

   initial begin
      do_reset(2'h0);
      t_regs();
      t_straps();
      do_reset(2'h0);
      t_serial();
      t_pdn();
      end_sim();
   end
endmodule
